// [design/ffoc_host.sv]
/*
 * Controller end: AXI4-Lite register slave that turns command writes into
 * pin sequences on the FIFO link and reports flags and interrupts.
 * Assumes the device samples pins on the same aclk.
 */
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module ffoc_host
	import ffoc_pkg::*;
#(
	parameter int WIDTH    = ffoc_pkg::WIDTH_DEF,
	parameter int MRST_CYC = ffoc_pkg::MRST_CYC_DEF
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic                   irq,
	ffoc_if.host                   link
);
	import ffoc_pkg::*;

	logic [ADDR_W-1:0] aw_addr_q;
	logic              aw_hold_q;
	logic [31:0]       w_data_q;
	logic [3:0]        w_strb_q;
	logic              w_hold_q;
	logic              wr_fire;
	logic [95:0]       wd_q;
	logic [95:0]       rd_q;
	logic [IRQ_W-1:0]  irq_st_q;
	logic [IRQ_W-1:0]  irq_en_q;
	logic [IRQ_W-1:0]  ev;
	logic              full_now;
	logic              empty_now;
	logic              full_prev_q;
	logic              empty_prev_q;
	ffoc_state_type    state_q;
	ffoc_op_type       op_q;
	logic [7:0]        cnt_q;
	logic              start;
	logic              done;

	// ****************************************
	// AXI4-Lite write path
	// ****************************************
	assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_hold_q & ~s_axi_bvalid;
	assign wr_fire       = aw_hold_q & w_hold_q;
	assign start         = wr_fire && aw_addr_q == REG_CMD && w_strb_q[0] && state_q == ST_IDLE;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			aw_addr_q <= '0;
			w_data_q  <= '0;
			w_strb_q  <= '0;
		end else if (wr_fire) begin
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			if (aw_addr_q == REG_CMD || aw_addr_q == REG_WD0 || aw_addr_q == REG_WD1
				|| aw_addr_q == REG_WD2 || aw_addr_q == REG_IRQ_CL || aw_addr_q == REG_IRQ_EN) begin
				s_axi_bresp <= RESP_OKAY;
			end else begin
				s_axi_bresp <= RESP_SLVERR;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Write data words with byte strobes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wd_q <= '0;
		end else if (wr_fire) begin
			for (int b = 0; b < 4; b++) begin
				if (w_strb_q[b] && aw_addr_q == REG_WD0) begin
					wd_q[b*8 +: 8] <= w_data_q[b*8 +: 8];
				end else if (w_strb_q[b] && aw_addr_q == REG_WD1) begin
					wd_q[32 + b*8 +: 8] <= w_data_q[b*8 +: 8];
				end else if (w_strb_q[b] && aw_addr_q == REG_WD2) begin
					wd_q[64 + b*8 +: 8] <= w_data_q[b*8 +: 8];
				end
			end
		end
	end

	// ****************************************
	// Interrupts
	// ****************************************
	assign full_now  = link.first_word_through_mode ? link.input_room_n : ~link.full_flag;
	assign empty_now = link.first_word_through_mode ? link.output_valid_n : ~link.empty_flag;
	assign ev        = {empty_now & ~empty_prev_q, full_now & ~full_prev_q, done};
	assign irq       = |(irq_st_q & irq_en_q);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			full_prev_q  <= 1'b0;
			empty_prev_q <= 1'b1;
		end else begin
			full_prev_q  <= full_now;
			empty_prev_q <= empty_now;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_st_q <= '0;
		end else if (wr_fire && aw_addr_q == REG_IRQ_CL && w_strb_q[0]) begin
			irq_st_q <= (irq_st_q & ~w_data_q[IRQ_W-1:0]) | ev;
		end else begin
			irq_st_q <= irq_st_q | ev;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_en_q <= '0;
		end else if (wr_fire && aw_addr_q == REG_IRQ_EN && w_strb_q[0]) begin
			irq_en_q <= w_data_q[IRQ_W-1:0];
		end
	end

	// ****************************************
	// AXI4-Lite read path
	// ****************************************
	assign s_axi_arready = ~s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= RESP_OKAY;
			s_axi_rdata  <= '0;
			if (s_axi_araddr == REG_RD0) begin
				s_axi_rdata <= rd_q[31:0];
			end else if (s_axi_araddr == REG_RD1) begin
				s_axi_rdata <= rd_q[63:32];
			end else if (s_axi_araddr == REG_RD2) begin
				s_axi_rdata <= rd_q[95:64];
			end else if (s_axi_araddr == REG_FLAGS) begin
				s_axi_rdata <= {24'h000000, state_q != ST_IDLE, link.input_room_n,
					link.output_valid_n, link.full_flag, link.almost_full,
					link.half_level, link.almost_empty, link.empty_flag};
			end else if (s_axi_araddr == REG_IRQ_ST) begin
				s_axi_rdata <= 32'(irq_st_q);
			end else if (s_axi_araddr == REG_IRQ_EN) begin
				s_axi_rdata <= 32'(irq_en_q);
			end else begin
				s_axi_rresp <= RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ****************************************
	// Link sequencer
	// ****************************************
	assign done = (state_q == ST_CAPT) || (state_q == ST_RESET && cnt_q == '0);
	assign link.input_bus = wd_q[WIDTH-1:0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= ST_IDLE;
			op_q    <= OP_NONE;
			cnt_q   <= '0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start) begin
						op_q    <= ffoc_op_type'(w_data_q[CMD_OP_LSB +: 3]);
						cnt_q   <= 8'(MRST_CYC - 1);
						state_q <= (w_data_q[CMD_OP_LSB +: 3] == OP_MRST) ? ST_RESET : ST_SETUP;
					end
				end
				ST_SETUP: state_q <= ST_PULSE;
				ST_PULSE: state_q <= ST_CAPT;
				ST_CAPT:  state_q <= ST_IDLE;
				ST_RESET: begin
					cnt_q <= cnt_q - 8'h01;
					if (cnt_q == '0) begin
						state_q <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Request pins from flops; all high means no operation.
	always_ff @(posedge aclk) begin
		if (!aresetn || done) begin
			link.master_reset_n    <= 1'b1;
			link.partial_reset_n   <= 1'b1;
			link.offset_access_sel <= 1'b1;
			link.write_request_n   <= 1'b1;
			link.read_request_n    <= 1'b1;
			link.serial_load_n     <= 1'b1;
			link.serial_in_bit     <= 1'b0;
		end else if (start) begin
			link.serial_in_bit <= w_data_q[CMD_SI_BIT];
			case (ffoc_op_type'(w_data_q[CMD_OP_LSB +: 3]))
				OP_MEM_WR: link.write_request_n <= 1'b0;
				OP_MEM_RD: link.read_request_n <= 1'b0;
				OP_OFS_WR: begin
					link.offset_access_sel <= 1'b0;
					link.write_request_n   <= 1'b0;
				end
				OP_OFS_RD: begin
					link.offset_access_sel <= 1'b0;
					link.read_request_n    <= 1'b0;
				end
				OP_SHIFT: begin
					link.offset_access_sel <= 1'b0;
					link.serial_load_n     <= 1'b0;
				end
				OP_MRST: begin
					link.master_reset_n    <= 1'b0;
					link.offset_access_sel <= w_data_q[CMD_SEL];
				end
				OP_PRST:  link.partial_reset_n <= 1'b0;
				default:  link.serial_in_bit <= 1'b0;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			link.first_word_through_mode <= 1'b0;
		end else if (start && w_data_q[CMD_OP_LSB +: 3] == OP_MRST) begin
			link.first_word_through_mode <= w_data_q[CMD_FIRST_WORD_THROUGH_MODE];
		end
	end

	// Side clock enables, one cycle in ST_PULSE
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			link.write_side_clk_en <= 1'b0;
			link.read_side_clk_en  <= 1'b0;
			link.serial_clk_en     <= 1'b0;
		end else begin
			link.write_side_clk_en <= state_q == ST_SETUP && (op_q == OP_MEM_WR || op_q == OP_OFS_WR);
			link.read_side_clk_en  <= state_q == ST_SETUP && (op_q == OP_MEM_RD || op_q == OP_OFS_RD);
			link.serial_clk_en     <= state_q == ST_SETUP && op_q == OP_SHIFT;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_q <= '0;
		end else if (state_q == ST_CAPT && (op_q == OP_MEM_RD || op_q == OP_OFS_RD)) begin
			rd_q <= 96'(link.output_bus);
		end
	end

endmodule : ffoc_host

`default_nettype wire

// [design/ffoc_pkg.sv]
/*
 * Shared constants and types for the FIFO flag and offset control block.
 * Assumes a single 200 MHz clock; the side clocks of the FIFO are carried
 * as one-cycle enable pulses on that clock.
 */
`default_nettype none

package ffoc_pkg;

	// ****************************************
	// FIFO geometry
	// ****************************************
	localparam int         DEPTH_DEF     = 512;
	localparam int         WIDTH_DEF     = 72;
	localparam int         OFS_W_DEF     = 9;
	localparam logic [8:0] EMPTY_OFS_RST = 9'h07F;
	localparam logic [8:0] FULL_OFS_RST  = 9'h07F;
	localparam int         MRST_CYC_DEF  = 4;

	// ****************************************
	// Host command codes and states
	// ****************************************
	typedef enum logic [2:0] {
		OP_NONE   = 3'b000,
		OP_MEM_WR = 3'b001,
		OP_MEM_RD = 3'b010,
		OP_OFS_WR = 3'b011,
		OP_OFS_RD = 3'b100,
		OP_SHIFT  = 3'b101,
		OP_MRST   = 3'b110,
		OP_PRST   = 3'b111
	} ffoc_op_type;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_SETUP = 3'b001,
		ST_PULSE = 3'b010,
		ST_CAPT  = 3'b011,
		ST_RESET = 3'b100
	} ffoc_state_type;

	// ****************************************
	// Host register map
	// ****************************************
	localparam int          ADDR_W     = 12;
	localparam logic [11:0] REG_CMD    = 12'h000;
	localparam logic [11:0] REG_WD0    = 12'h004;
	localparam logic [11:0] REG_WD1    = 12'h008;
	localparam logic [11:0] REG_WD2    = 12'h00C;
	localparam logic [11:0] REG_RD0    = 12'h010;
	localparam logic [11:0] REG_RD1    = 12'h014;
	localparam logic [11:0] REG_RD2    = 12'h018;
	localparam logic [11:0] REG_FLAGS  = 12'h01C;
	localparam logic [11:0] REG_IRQ_ST = 12'h020;
	localparam logic [11:0] REG_IRQ_CL = 12'h024;
	localparam logic [11:0] REG_IRQ_EN = 12'h028;

	localparam int CMD_OP_LSB = 0;
	localparam int CMD_SI_BIT = 3;
	localparam int CMD_SEL    = 4;
	localparam int CMD_FIRST_WORD_THROUGH_MODE   = 5;

	localparam int IRQ_DONE  = 0;
	localparam int IRQ_FULL  = 1;
	localparam int IRQ_EMPTY = 2;
	localparam int IRQ_W     = 3;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : ffoc_pkg

`default_nettype wire

// [design/ffoc_if.sv]
/*
 * Pin-level link between the FIFO flag/offset device and its controller.
 * Assumes both ends run on the same aclk; side clocks are enable pulses.
 */
`timescale 1ns/100ps
`default_nettype none

interface ffoc_if #(
	parameter int WIDTH = 72,
	parameter int OW    = 9
) ();
	logic             master_reset_n;
	logic             partial_reset_n;
	logic             first_word_through_mode;
	logic             offset_access_sel;
	logic             write_request_n;
	logic             read_request_n;
	logic             serial_load_n;
	logic             write_side_clk_en;
	logic             read_side_clk_en;
	logic             serial_clk_en;
	logic             serial_in_bit;
	logic [WIDTH-1:0] input_bus;
	logic [WIDTH-1:0] output_bus;
	logic             empty_flag;
	logic             almost_empty;
	logic             half_level;
	logic             almost_full;
	logic             full_flag;
	logic             output_valid_n;
	logic             input_room_n;

	modport device (
		input  master_reset_n, partial_reset_n, first_word_through_mode,
		input  offset_access_sel, write_request_n, read_request_n, serial_load_n,
		input  write_side_clk_en, read_side_clk_en, serial_clk_en,
		input  serial_in_bit, input_bus,
		output output_bus, empty_flag, almost_empty, half_level,
		output almost_full, full_flag, output_valid_n, input_room_n
	);

	modport host (
		output master_reset_n, partial_reset_n, first_word_through_mode,
		output offset_access_sel, write_request_n, read_request_n, serial_load_n,
		output write_side_clk_en, read_side_clk_en, serial_clk_en,
		output serial_in_bit, input_bus,
		input  output_bus, empty_flag, almost_empty, half_level,
		input  almost_full, full_flag, output_valid_n, input_room_n
	);
endinterface : ffoc_if

`default_nettype wire

// [design/ffoc_device.sv]
/*
 * FIFO device end: word store, status flags for standard and
 * first-word-fall-through timing, and the offset register access decode.
 * Assumes the controller drives the pins from flops on aclk and gives each
 * side clock as a one-cycle enable.
 */
`timescale 1ns/100ps
`default_nettype none

module ffoc_device
	import ffoc_pkg::*;
#(
	parameter int DEPTH = ffoc_pkg::DEPTH_DEF,
	parameter int WIDTH = ffoc_pkg::WIDTH_DEF,
	parameter int OW    = $clog2(DEPTH)
) (
	input wire logic aclk,
	input wire logic aresetn,
	ffoc_if.device   link
);
	import ffoc_pkg::*;

	// ****************************************
	// Local sizes
	// ****************************************
	localparam int            CW       = $clog2(DEPTH + 2);
	localparam int            PW       = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] CAP_STD  = CW'(DEPTH);
	localparam logic [CW-1:0] CAP_FIRST_WORD_THROUGH_MODE = CW'(DEPTH + 1);
	localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH);
	localparam logic [OW-1:0] EMPTY_D  = OW'(EMPTY_OFS_RST);
	localparam logic [OW-1:0] FULL_D   = OW'(FULL_OFS_RST);

	logic [WIDTH-1:0] mem [0:DEPTH];
	logic [CW-1:0]    count_q;
	logic [PW-1:0]    wr_addr_q;
	logic [PW-1:0]    rd_addr_q;
	logic [OW-1:0]    empty_ofs_q;
	logic [OW-1:0]    full_ofs_q;
	logic             ofs_wptr_q;
	logic             ofs_rptr_q;
	logic             serial_mode_q;
	logic             first_word_through_mode_q;
	logic [WIDTH-1:0] out_q;
	logic             empty_q;
	logic             ae_q;
	logic             half_q;
	logic             af_q;
	logic             full_q;
	logic             ovn_q;
	logic             irn_q;
	logic             empty_d;
	logic             ae_d;
	logic             half_d;
	logic             af_d;
	logic             full_d;
	logic             ovn_d;
	logic             irn_d;
	logic [CW-1:0]    cap;
	logic             mrst;
	logic             prst;
	logic             ofs_wr;
	logic             ofs_rd;
	logic             ofs_sh;
	logic             mem_wr;
	logic             mem_rd;

	// ****************************************
	// Access decode
	// ****************************************
	assign mrst = ~link.master_reset_n;
	assign prst = ~link.partial_reset_n;
	assign cap  = first_word_through_mode_q ? CAP_FIRST_WORD_THROUGH_MODE : CAP_STD;

	// Offset decode ignores the timing mode on purpose.
	assign ofs_wr = ~link.offset_access_sel & ~link.write_request_n & link.read_request_n
		& link.serial_load_n & link.write_side_clk_en & ~serial_mode_q;
	assign ofs_rd = ~link.offset_access_sel & link.write_request_n & ~link.read_request_n
		& link.serial_load_n & link.read_side_clk_en;
	assign ofs_sh = ~link.offset_access_sel & link.write_request_n & link.read_request_n
		& ~link.serial_load_n & link.serial_clk_en & serial_mode_q;
	assign mem_wr = link.offset_access_sel & ~link.write_request_n
		& link.write_side_clk_en & (count_q < cap);
	assign mem_rd = link.offset_access_sel & ~link.read_request_n
		& link.read_side_clk_en & (count_q != '0);

	// ****************************************
	// Modes caught at master reset
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			serial_mode_q <= 1'b0;
			first_word_through_mode_q        <= 1'b0;
		end else if (mrst) begin
			serial_mode_q <= link.offset_access_sel;
			first_word_through_mode_q        <= link.first_word_through_mode;
		end
	end

	// ****************************************
	// Offset registers
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn || mrst) begin
			empty_ofs_q <= EMPTY_D;
			full_ofs_q  <= FULL_D;
		end else if (ofs_wr) begin
			if (ofs_wptr_q) begin
				full_ofs_q <= link.input_bus[OW-1:0];
			end else begin
				empty_ofs_q <= link.input_bus[OW-1:0];
			end
		end else if (ofs_sh) begin
			// New bit enters at the full MSB end.
			{full_ofs_q, empty_ofs_q} <= {link.serial_in_bit, full_ofs_q, empty_ofs_q[OW-1:1]};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || mrst) begin
			ofs_wptr_q <= 1'b0;
			ofs_rptr_q <= 1'b0;
		end else begin
			if (ofs_wr) begin
				ofs_wptr_q <= ~ofs_wptr_q;
			end
			if (ofs_rd) begin
				ofs_rptr_q <= ~ofs_rptr_q;
			end
		end
	end

	// ****************************************
	// Word store
	// ****************************************
	always_ff @(posedge aclk) begin
		if (mem_wr) begin
			mem[wr_addr_q] <= link.input_bus;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || mrst || prst) begin
			wr_addr_q <= '0;
			rd_addr_q <= '0;
		end else begin
			if (mem_wr) begin
				wr_addr_q <= (wr_addr_q == PTR_LAST) ? '0 : wr_addr_q + 1'b1;
			end
			if (mem_rd) begin
				rd_addr_q <= (rd_addr_q == PTR_LAST) ? '0 : rd_addr_q + 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || mrst || prst) begin
			count_q <= '0;
		end else if (mem_wr && !mem_rd) begin
			count_q <= count_q + 1'b1;
		end else if (mem_rd && !mem_wr) begin
			count_q <= count_q - 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || mrst) begin
			out_q <= '0;
		end else if (ofs_rd) begin
			out_q <= WIDTH'(ofs_rptr_q ? full_ofs_q : empty_ofs_q);
		end else if (mem_rd) begin
			out_q <= mem[rd_addr_q];
		end
	end

	// ****************************************
	// Status flags, all active low
	// ****************************************
	always_comb begin
		int cnt;
		int n;
		int m;
		cnt     = int'(count_q);
		n       = int'(empty_ofs_q);
		m       = int'(full_ofs_q);
		empty_d = 1'b1;
		ovn_d   = 1'b1;
		full_d  = 1'b1;
		irn_d   = 1'b1;
		if (first_word_through_mode_q) begin
			ovn_d  = (cnt == 0);
			ae_d   = (cnt > n + 1);
			half_d = !(cnt >= DEPTH / 2 + 2);
			af_d   = !(cnt >= DEPTH + 1 - m);
			irn_d  = (cnt == DEPTH + 1);
		end else begin
			empty_d = (cnt != 0);
			ae_d    = (cnt > n);
			half_d  = !(cnt > DEPTH / 2);
			af_d    = !(cnt >= DEPTH - m);
			full_d  = !(cnt == DEPTH);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			empty_q <= 1'b0;
			ae_q    <= 1'b0;
			half_q  <= 1'b1;
			af_q    <= 1'b1;
			full_q  <= 1'b1;
			ovn_q   <= 1'b1;
			irn_q   <= 1'b1;
		end else begin
			empty_q <= empty_d;
			ae_q    <= ae_d;
			half_q  <= half_d;
			af_q    <= af_d;
			full_q  <= full_d;
			ovn_q   <= ovn_d;
			irn_q   <= irn_d;
		end
	end

	assign link.output_bus     = out_q;
	assign link.empty_flag     = empty_q;
	assign link.almost_empty   = ae_q;
	assign link.half_level     = half_q;
	assign link.almost_full    = af_q;
	assign link.full_flag      = full_q;
	assign link.output_valid_n = ovn_q;
	assign link.input_room_n   = irn_q;

endmodule : ffoc_device

`default_nettype wire

// [bench/ffoc_properties.sv]
/*
 * Checker on the flag/offset link between host and device ends.
 * Assumes one aclk domain; sits beside the interface in the bench.
 */
`timescale 1ns/100ps
`default_nettype none

module ffoc_properties (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic master_reset_n,
	input wire logic offset_access_sel,
	input wire logic write_request_n,
	input wire logic read_request_n,
	input wire logic serial_load_n,
	input wire logic write_side_clk_en,
	input wire logic serial_clk_en,
	input wire logic empty_flag,
	input wire logic almost_empty,
	input wire logic half_level,
	input wire logic almost_full,
	input wire logic full_flag,
	input wire logic output_valid_n,
	input wire logic input_room_n
);
	// ****************************************
	// Link properties
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_emp; !empty_flag |-> !almost_empty && half_level && almost_full && full_flag;
	endproperty
	a_emp: assert property (p_emp) else $error("flags wrong while empty");
	property p_full; !full_flag |-> !almost_full && !half_level && almost_empty && empty_flag;
	endproperty
	a_full: assert property (p_full) else $error("flags wrong while full");
	property p_ovn; !output_valid_n |-> empty_flag && full_flag; endproperty
	a_ovn: assert property (p_ovn) else $error("standard flags active in first_word_through_mode");
	property p_room; !output_valid_n && input_room_n |-> !almost_full && !half_level && almost_empty;
	endproperty
	a_room: assert property (p_room) else $error("flags wrong at first_word_through_mode capacity");
	property p_wen; write_side_clk_en |-> !write_request_n && read_request_n ##1 !write_side_clk_en;
	endproperty
	a_wen: assert property (p_wen) else $error("bad write pulse");
	property p_sen; serial_clk_en |-> !serial_load_n && !offset_access_sel; endproperty
	a_sen: assert property (p_sen) else $error("bad serial pulse");
	property p_mrst; $fell(master_reset_n) |-> !master_reset_n [*4]; endproperty
	a_mrst: assert property (p_mrst) else $error("master reset too short");
	property p_first; write_side_clk_en && offset_access_sel && !empty_flag |-> ##2 empty_flag;
	endproperty
	a_first: assert property (p_first) else $error("first word not flagged");
	c_full: cover property (!full_flag);
	c_shift: cover property (serial_clk_en);
	c_room: cover property (!output_valid_n && input_room_n);
endmodule : ffoc_properties

`default_nettype wire

// [bench/ffoc_bench.sv]
/*
 * Bench: host and device joined by the link, driven over AXI4-Lite.
 * Assumes package, interface and both design ends compiled first.
 */
`timescale 1ns/100ps
`default_nettype none

module ffoc_bench;
	import ffoc_pkg::*;
	localparam int D = 16;
	logic aclk = 0, aresetn = 0, irq;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	int failures = 0, total_checks = 0, cyc = 0, n = 2, m = 3;
	ffoc_if #(.OW(4)) link ();
	ffoc_device #(.DEPTH(D)) u_ffoc_device (.aclk(aclk), .aresetn(aresetn), .link(link));
	ffoc_host u_ffoc_host (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .link(link));
	ffoc_properties u_ffoc_properties (.aclk(aclk), .aresetn(aresetn),
		.master_reset_n(link.master_reset_n), .offset_access_sel(link.offset_access_sel),
		.write_request_n(link.write_request_n), .read_request_n(link.read_request_n),
		.serial_load_n(link.serial_load_n), .write_side_clk_en(link.write_side_clk_en),
		.serial_clk_en(link.serial_clk_en), .empty_flag(link.empty_flag),
		.almost_empty(link.almost_empty), .half_level(link.half_level),
		.almost_full(link.almost_full), .full_flag(link.full_flag),
		.output_valid_n(link.output_valid_n), .input_room_n(link.input_room_n));

	// ****************************************
	// Tasks
	// ****************************************
	task conclude;
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : conclude
	task chk(string s, logic [31:0] seen, logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s exp %h seen %h", s, exp, seen);
		end
	endtask : chk
	task wr(logic [11:0] a, logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask : wr
	task rdr(logic [11:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask : rdr
	task cmd(logic [5:0] c);
		wr(REG_CMD, {26'h0, c});
		do rdr(REG_FLAGS); while (rd[7] !== 1'h0);
		repeat (3) @(posedge aclk);
	endtask : cmd
	function logic [6:0] ef(int c, bit f);
		if (f) return {c == D + 1, c == 0, 1'h1, c < D + 1 - m, c < D / 2 + 2, c > n + 1, 1'h1};
		return {2'h3, c != D, c < D - m, c <= D / 2, c > n, c != 0};
	endfunction : ef
	task fill(bit f);
		for (int c = 1; c <= D + 2; c++) begin
			cmd(6'h01);
			rdr(REG_FLAGS);
			chk("flags", {25'h0, rd[6:0]}, {25'h0, ef(c > D + f ? D + f : c, f)});
		end
	endtask : fill
	task ofs(int e);
		cmd(6'h04);
		rdr(REG_RD0);
		chk("offset", rd, e);
	endtask : ofs

	// ****************************************
	// Clock, timeout and tests
	// ****************************************
	initial forever #2.5 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			conclude();
		end
	end
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		rdr(REG_FLAGS);
		chk("reset flags", rd[6:0], 7'h7C);
		rdr(12'h030);
		chk("unmapped", rsp, RESP_SLVERR);
		wr(REG_RD0, 32'h0);
		chk("unmapped write", rsp, RESP_SLVERR);
		wr(REG_WD0, n);
		cmd(6'h03);
		wr(REG_WD0, m);
		cmd(6'h03);
		ofs(n);
		ofs(m);
		wr(REG_IRQ_EN, 32'h1);
		fill(1'h0);
		chk("irq set", irq, 1);
		rdr(REG_IRQ_ST);
		chk("irq status", rd, 32'h3);
		wr(REG_IRQ_CL, 32'h7);
		repeat (2) @(posedge aclk);
		chk("irq clear", irq, 0);
		$display("standard test done");
		cmd(6'h36);
		n = 1;
		m = 2;
		for (int i = 0; i < 8; i++) cmd({2'h0, 1'((m * 16 + n) >> i), 3'h5});
		wr(REG_WD0, 5);
		cmd(6'h03);
		ofs(n);
		fill(1'h1);
		cmd(6'h07);
		rdr(REG_FLAGS);
		chk("partial", rd[6:0], ef(0, 1));
		ofs(m);
		wr(REG_IRQ_CL, 32'h7);
		wr(REG_WD0, 32'h89ABCDEF);
		wr(REG_WD1, 32'h01234567);
		wr(REG_WD2, 32'h000000A5);
		cmd(6'h01);
		cmd(6'h02);
		rdr(REG_RD0);
		chk("word low", rd, 32'h89ABCDEF);
		rdr(REG_RD1);
		chk("word mid", rd, 32'h01234567);
		rdr(REG_RD2);
		chk("word high", rd, 32'h000000A5);
		cmd(6'h02);
		rdr(REG_FLAGS);
		chk("read at empty", rd[6:0], ef(0, 1));
		rdr(REG_IRQ_ST);
		chk("irq events", rd, 32'h5);
		$display("first_word_through_mode serial test done");
		conclude();
	end
endmodule : ffoc_bench

`default_nettype wire
